// ### core/odcb_defs.svh
// Register offsets, field layouts, reset values and codes of the output divider bank.
`ifndef ODCB_DEFS_SVH
`define ODCB_DEFS_SVH

// ****************************************************************
// Register numbers
// ****************************************************************
`define ODCB_ADDR_PREV_MISC 8'h1f
`define ODCB_ADDR_DIV_HIGH 8'h20
`define ODCB_ADDR_DIV_MID 8'h21
`define ODCB_ADDR_DIV_LOW 8'h22
`define ODCB_ADDR_PHASE_STR 8'h23
`define ODCB_ADDR_DELAY 8'h24
`define ODCB_ADDR_DRV_MISC 8'h25
`define ODCB_ADDR_STATUS 8'h26
`define ODCB_ADDR_FMT_MISC 8'h27

// ****************************************************************
// Reset value and writable bits
// ****************************************************************
`define ODCB_RST_VAL 8'h00
`define ODCB_MASK_DIV_HIGH 8'h0f
`define ODCB_MASK_FULL 8'hff
`define ODCB_MASK_PHASE_STR 8'hc7
`define ODCB_MASK_MISC 8'h1f
`define ODCB_MASK_NONE 8'h00

// ****************************************************************
// Output format codes
// ****************************************************************
`define ODCB_FMT_CODE_EXT 4'h0
`define ODCB_FMT_CODE_PULL_UP 4'h2
`define ODCB_FMT_CODE_PULL_DN 4'h1
`define ODCB_FMT_CODE_CMOS_POS 4'h4
`define ODCB_FMT_CODE_CMOS_NEG 4'h8
`define ODCB_FMT_CODE_CMOS_BOTH 4'hc

// ****************************************************************
// Delay figures and divider commit mask
// ****************************************************************
`define ODCB_FINE_STEP_PS 7'h1e
`define ODCB_FINE_MAX_STEPS 3'h4
`define ODCB_DIV_ALL_WRITTEN 3'h7

`endif

// ### core/odcb_pkg.sv
// Types shared by the output divider bank modules.
package odcb_pkg;

  typedef enum logic [2:0] {
    odcb_fmt_ext_term = 3'h0,
    odcb_fmt_pull_up = 3'h1,
    odcb_fmt_pull_dn = 3'h2,
    odcb_fmt_cmos_pos = 3'h3,
    odcb_fmt_cmos_neg = 3'h4,
    odcb_fmt_cmos_both = 3'h5,
    odcb_fmt_invalid = 3'h7
  } odcb_format_t;

  typedef enum logic [2:0] {
    odcb_drv_lvds = 3'h0,
    odcb_drv_lvpecl = 3'h1,
    odcb_drv_cml = 3'h2,
    odcb_drv_hcsl = 3'h3,
    odcb_drv_lvds_boost = 3'h4,
    odcb_drv_lvpecl_nocm = 3'h5,
    odcb_drv_invalid = 3'h7
  } odcb_drv_std_t;

  typedef enum logic [1:0] {
    odcb_vdd_1v8 = 2'h0,
    odcb_vdd_2v5 = 2'h1,
    odcb_vdd_3v3 = 2'h2,
    odcb_vdd_invalid = 2'h3
  } odcb_supply_t;

endpackage

// ### core/odcb_cfg_if.sv
// Configuration carrier between the bank and its divider and decode stages.
`timescale 1ns/1ps
`default_nettype none
interface odcb_cfg_if;
  import odcb_pkg::*;
  logic [7:0] div_high;
  logic [7:0] div_mid;
  logic [7:0] div_low;
  logic [2:0] div_wr;
  logic [19:0] div_active;
  logic [2:0] div_mask;
  logic div_commit;
  logic [1:0] phase_sel;
  logic [3:0] fmt_bits;
  logic [2:0] drv_bits;
  logic [1:0] supply_bits;
  logic [2:0] fine_code;
  odcb_format_t fmt;
  odcb_drv_std_t drv_std;
  odcb_supply_t supply;
  logic pos_uses_comp;
  logic neg_uses_comp;
  logic pos_en;
  logic neg_en;
  logic [2:0] fine_steps;
  logic [6:0] fine_ps;

  modport bank (
    output div_high, div_mid, div_low, div_wr, phase_sel, fmt_bits, drv_bits, supply_bits,
    output fine_code,
    input div_active, div_mask, div_commit, fmt, drv_std, supply, pos_uses_comp,
    input neg_uses_comp, pos_en, neg_en, fine_steps, fine_ps
  );
  modport div (
    input div_high, div_mid, div_low, div_wr,
    output div_active, div_mask, div_commit
  );
  modport dec (
    input phase_sel, fmt_bits, drv_bits, supply_bits, fine_code,
    output fmt, drv_std, supply, pos_uses_comp, neg_uses_comp, pos_en, neg_en,
    output fine_steps, fine_ps
  );
endinterface
`default_nettype wire

// ### core/odcb_div_stage.sv
// Divider staging: the 20-bit ratio takes effect once all three bytes are written.
`timescale 1ns/1ps
`default_nettype none
`include "odcb_defs.svh"
module odcb_div_stage (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  odcb_cfg_if.div cfg
);
  import odcb_pkg::*;

  logic [2:0] mask_reg;
  logic [2:0] mask_next;
  logic [19:0] active_reg;

  // A byte written in the commit cycle starts the next set; it is never lost.
  assign cfg.div_commit = (mask_reg == `ODCB_DIV_ALL_WRITTEN);
  assign mask_next = (cfg.div_commit ? 3'h0 : mask_reg) | cfg.div_wr;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      mask_reg <= 3'h0;
    end else begin
      mask_reg <= mask_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      active_reg <= 20'h00000;
    end else if (cfg.div_commit) begin
      active_reg <= {cfg.div_high[3:0], cfg.div_mid, cfg.div_low};
    end
  end

  assign cfg.div_active = active_reg;
  assign cfg.div_mask = mask_reg;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  chk_div_assembly: assert property (cfg.div_commit |=> cfg.div_active ==
      {$past(cfg.div_high[3:0]), $past(cfg.div_mid), $past(cfg.div_low)})
    else $error("divider ratio not assembled from the three bytes");
  chk_div_hold: assert property (!cfg.div_commit |=> $stable(cfg.div_active))
    else $error("divider ratio changed without a full byte set");
  chk_div_restart: assert property (cfg.div_commit |=> cfg.div_mask == $past(cfg.div_wr))
    else $error("byte written during commit was lost");
  cov_div_commit: cover property (cfg.div_commit ##1 cfg.div_active != 20'h00000);
endmodule // odcb_div_stage
`default_nettype wire

// ### core/odcb_drv_decode.sv
// Registered decode of phase, format, driver standard, supply and fine delay fields.
`timescale 1ns/1ps
`default_nettype none
`include "odcb_defs.svh"
module odcb_drv_decode (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  odcb_cfg_if.dec cfg
);
  import odcb_pkg::*;

  function automatic odcb_format_t odcb_decode_fmt(input logic [3:0] bits);
    odcb_format_t f;
    f = odcb_fmt_invalid;
    case (bits)
      `ODCB_FMT_CODE_EXT: f = odcb_fmt_ext_term;
      `ODCB_FMT_CODE_PULL_UP: f = odcb_fmt_pull_up;
      `ODCB_FMT_CODE_PULL_DN: f = odcb_fmt_pull_dn;
      `ODCB_FMT_CODE_CMOS_POS: f = odcb_fmt_cmos_pos;
      `ODCB_FMT_CODE_CMOS_NEG: f = odcb_fmt_cmos_neg;
      `ODCB_FMT_CODE_CMOS_BOTH: f = odcb_fmt_cmos_both;
      default: f = odcb_fmt_invalid;
    endcase
    return f;
  endfunction

  function automatic logic [2:0] odcb_clamp_fine(input logic [2:0] code);
    return (code > `ODCB_FINE_MAX_STEPS) ? `ODCB_FINE_MAX_STEPS : code;
  endfunction

  odcb_format_t fmt_c;
  logic is_cmos;
  logic [2:0] steps_c;

  assign fmt_c = odcb_decode_fmt(cfg.fmt_bits);
  assign is_cmos = (fmt_c == odcb_fmt_cmos_pos) || (fmt_c == odcb_fmt_cmos_neg) ||
                   (fmt_c == odcb_fmt_cmos_both);
  assign steps_c = odcb_clamp_fine(cfg.fine_code);

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cfg.fmt <= odcb_fmt_ext_term;
      cfg.pos_en <= 1'b1;
      cfg.neg_en <= 1'b1;
    end else begin
      cfg.fmt <= fmt_c;
      cfg.pos_en <= (fmt_c != odcb_fmt_invalid) && (fmt_c != odcb_fmt_cmos_neg);
      cfg.neg_en <= (fmt_c != odcb_fmt_invalid) && (fmt_c != odcb_fmt_cmos_pos);
    end
  end

  // Differential formats ignore the phase field so the pair never loses polarity.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cfg.pos_uses_comp <= 1'b0;
      cfg.neg_uses_comp <= 1'b1;
    end else begin
      cfg.pos_uses_comp <= is_cmos & cfg.phase_sel[1];
      cfg.neg_uses_comp <= ~is_cmos | ~cfg.phase_sel[0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cfg.drv_std <= odcb_drv_lvds;
      cfg.supply <= odcb_vdd_1v8;
    end else begin
      case (cfg.drv_bits)
        odcb_drv_lvds: cfg.drv_std <= odcb_drv_lvds;
        odcb_drv_lvpecl: cfg.drv_std <= odcb_drv_lvpecl;
        odcb_drv_cml: cfg.drv_std <= odcb_drv_cml;
        odcb_drv_hcsl: cfg.drv_std <= odcb_drv_hcsl;
        odcb_drv_lvds_boost: cfg.drv_std <= odcb_drv_lvds_boost;
        odcb_drv_lvpecl_nocm: cfg.drv_std <= odcb_drv_lvpecl_nocm;
        default: cfg.drv_std <= odcb_drv_invalid;
      endcase
      case (cfg.supply_bits)
        odcb_vdd_1v8: cfg.supply <= odcb_vdd_1v8;
        odcb_vdd_2v5: cfg.supply <= odcb_vdd_2v5;
        odcb_vdd_3v3: cfg.supply <= odcb_vdd_3v3;
        default: cfg.supply <= odcb_vdd_invalid;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cfg.fine_steps <= 3'h0;
      cfg.fine_ps <= 7'h00;
    end else begin
      cfg.fine_steps <= steps_c;
      cfg.fine_ps <= 7'({4'h0, steps_c} * `ODCB_FINE_STEP_PS);
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  chk_fine_ext_clamp: assert property (cfg.fine_code[2] |=>
      cfg.fine_steps == `ODCB_FINE_MAX_STEPS && cfg.fine_ps == 7'h78)
    else $error("extended fine delay not limited to four steps");
  chk_drv_cml_code: assert property (cfg.drv_bits == 3'h2 |=> cfg.drv_std == odcb_drv_cml)
    else $error("code 010 did not select CML");
endmodule // odcb_drv_decode
`default_nettype wire

// ### core/odcb_bank.sv
// Output divider configuration bank: host registers, clock sync, delay line and pin drivers.
`timescale 1ns/1ps
`default_nettype none
`include "odcb_defs.svh"
// ****************************************************************
// Behaviour
// - Divide ratio is twenty bits over three bytes.
// - Phase field picks true or complement per pin in CMOS formats.
// - Coarse delay of zero to sixty-three periods.
// - Two-bit fine delay adds 30 ps steps.
// - Extended three-bit fine delay reaches four steps.
// - Misc low nibble selects the output format.
// - Driver codes for boosted LVDS and LVPECL kinds.
// - Supply field declares 1.8, 2.5 or 3.3 V.
// - Driver codes for CML, HCSL and LVDS.
// ****************************************************************
module odcb_bank (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_reg_wr_en,
  input wire logic i_reg_rd_en,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rd_valid,
  input wire logic i_clock_true,
  output logic o_driver_out_pos,
  output logic o_driver_out_neg,
  output logic [19:0] o_output_divider,
  output logic o_div_update,
  output logic [2:0] o_drive_strength,
  output logic [8:0] o_output_delay_code,
  output logic [5:0] o_coarse_delay_periods,
  output logic [2:0] o_fine_delay_steps,
  output logic [6:0] o_fine_delay_ps,
  output var odcb_pkg::odcb_format_t o_output_format,
  output var odcb_pkg::odcb_drv_std_t o_driver_standard_select,
  output var odcb_pkg::odcb_supply_t o_output_supply_select,
  output logic [4:0] o_prev_format_misc
);
  import odcb_pkg::*;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] prev_misc_reg;
  logic [7:0] div_high_reg;
  logic [7:0] div_mid_reg;
  logic [7:0] div_low_reg;
  logic [7:0] phase_str_reg;
  logic [7:0] delay_reg;
  logic [7:0] drv_misc_reg;
  logic [7:0] fmt_misc_reg;
  logic [7:0] rd_data_next;

  odcb_cfg_if cfg ();

  // Unmapped and read-only numbers give an empty mask, so writes there do nothing.
  function automatic logic [7:0] odcb_write_mask(input logic [7:0] addr);
    logic [7:0] mask;
    mask = `ODCB_MASK_NONE;
    case (addr)
      `ODCB_ADDR_PREV_MISC: mask = `ODCB_MASK_MISC;
      `ODCB_ADDR_DIV_HIGH: mask = `ODCB_MASK_DIV_HIGH;
      `ODCB_ADDR_DIV_MID: mask = `ODCB_MASK_FULL;
      `ODCB_ADDR_DIV_LOW: mask = `ODCB_MASK_FULL;
      `ODCB_ADDR_PHASE_STR: mask = `ODCB_MASK_PHASE_STR;
      `ODCB_ADDR_DELAY: mask = `ODCB_MASK_FULL;
      `ODCB_ADDR_DRV_MISC: mask = `ODCB_MASK_MISC;
      `ODCB_ADDR_FMT_MISC: mask = `ODCB_MASK_MISC;
      default: mask = `ODCB_MASK_NONE;
    endcase
    return mask;
  endfunction

  function automatic logic odcb_wr_hit(input logic [7:0] target);
    return i_reg_wr_en && (i_reg_addr == target);
  endfunction

  // Reserved bits are dropped on write and therefore read back as zero.
  function automatic logic [7:0] odcb_store(input logic [7:0] wdata, input logic [7:0] addr);
    return wdata & odcb_write_mask(addr);
  endfunction

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      div_high_reg <= `ODCB_RST_VAL;
      div_mid_reg <= `ODCB_RST_VAL;
      div_low_reg <= `ODCB_RST_VAL;
    end else begin
      if (odcb_wr_hit(`ODCB_ADDR_DIV_HIGH)) begin
        div_high_reg <= odcb_store(i_reg_wdata, i_reg_addr);
      end
      if (odcb_wr_hit(`ODCB_ADDR_DIV_MID)) begin
        div_mid_reg <= odcb_store(i_reg_wdata, i_reg_addr);
      end
      if (odcb_wr_hit(`ODCB_ADDR_DIV_LOW)) begin
        div_low_reg <= odcb_store(i_reg_wdata, i_reg_addr);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      phase_str_reg <= `ODCB_RST_VAL;
      delay_reg <= `ODCB_RST_VAL;
    end else begin
      if (odcb_wr_hit(`ODCB_ADDR_PHASE_STR)) begin
        phase_str_reg <= odcb_store(i_reg_wdata, i_reg_addr);
      end
      if (odcb_wr_hit(`ODCB_ADDR_DELAY)) begin
        delay_reg <= odcb_store(i_reg_wdata, i_reg_addr);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      drv_misc_reg <= `ODCB_RST_VAL;
      fmt_misc_reg <= `ODCB_RST_VAL;
      prev_misc_reg <= `ODCB_RST_VAL;
    end else begin
      if (odcb_wr_hit(`ODCB_ADDR_DRV_MISC)) begin
        drv_misc_reg <= odcb_store(i_reg_wdata, i_reg_addr);
      end
      if (odcb_wr_hit(`ODCB_ADDR_FMT_MISC)) begin
        fmt_misc_reg <= odcb_store(i_reg_wdata, i_reg_addr);
      end
      if (odcb_wr_hit(`ODCB_ADDR_PREV_MISC)) begin
        prev_misc_reg <= odcb_store(i_reg_wdata, i_reg_addr);
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    case (i_reg_addr)
      `ODCB_ADDR_PREV_MISC: rd_data_next = prev_misc_reg;
      `ODCB_ADDR_DIV_HIGH: rd_data_next = div_high_reg;
      `ODCB_ADDR_DIV_MID: rd_data_next = div_mid_reg;
      `ODCB_ADDR_DIV_LOW: rd_data_next = div_low_reg;
      `ODCB_ADDR_PHASE_STR: rd_data_next = phase_str_reg;
      `ODCB_ADDR_DELAY: rd_data_next = delay_reg;
      `ODCB_ADDR_DRV_MISC: rd_data_next = drv_misc_reg;
      `ODCB_ADDR_STATUS: rd_data_next = {4'h0, cfg.div_commit, cfg.div_mask};
      `ODCB_ADDR_FMT_MISC: rd_data_next = fmt_misc_reg;
      default: rd_data_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_reg_rdata <= 8'h00;
      o_reg_rd_valid <= 1'b0;
    end else begin
      o_reg_rd_valid <= i_reg_rd_en;
      if (i_reg_rd_en) begin
        o_reg_rdata <= rd_data_next;
      end
    end
  end

  // ****************************************************************
  // Divider and decode stages
  // ****************************************************************
  assign cfg.div_high = div_high_reg;
  assign cfg.div_mid = div_mid_reg;
  assign cfg.div_low = div_low_reg;
  // A process rather than an assign, so that the strobe read inside the function wakes it.
  always_comb begin
    cfg.div_wr = {odcb_wr_hit(`ODCB_ADDR_DIV_HIGH), odcb_wr_hit(`ODCB_ADDR_DIV_MID),
                  odcb_wr_hit(`ODCB_ADDR_DIV_LOW)};
  end
  assign cfg.phase_sel = phase_str_reg[7:6];
  assign cfg.fmt_bits = fmt_misc_reg[3:0];
  assign cfg.drv_bits = drv_misc_reg[2:0];
  assign cfg.supply_bits = drv_misc_reg[4:3];
  assign cfg.fine_code = {fmt_misc_reg[4], delay_reg[7:6]};

  odcb_div_stage u_div_stage (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .cfg(cfg.div)
  );

  odcb_drv_decode u_drv_decode (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .cfg(cfg.dec)
  );

  // ****************************************************************
  // Clock input, coarse delay line and pin drivers
  // ****************************************************************
  logic clk_true_meta_reg;
  logic clk_true_sync_reg;
  logic [62:0] delay_line_reg;
  logic [63:0] delay_taps;
  logic delayed_clk;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      clk_true_meta_reg <= 1'b0;
      clk_true_sync_reg <= 1'b0;
    end else begin
      clk_true_meta_reg <= i_clock_true;
      clk_true_sync_reg <= clk_true_meta_reg;
    end
  end

  // One tap per reference period stands in for one VCO period of delay.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      delay_line_reg <= 63'h0;
    end else begin
      delay_line_reg <= {delay_line_reg[61:0], clk_true_sync_reg};
    end
  end

  assign delay_taps = {delay_line_reg, clk_true_sync_reg};
  assign delayed_clk = delay_taps[delay_reg[5:0]];

  // The complement is the inverted true clock, so choosing it is an XOR.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_driver_out_pos <= 1'b0;
      o_driver_out_neg <= 1'b0;
    end else begin
      o_driver_out_pos <= cfg.pos_en & (cfg.pos_uses_comp ^ delayed_clk);
      o_driver_out_neg <= cfg.neg_en & (cfg.neg_uses_comp ^ delayed_clk);
    end
  end

  // ****************************************************************
  // Configuration outputs
  // ****************************************************************
  assign o_output_divider = cfg.div_active;
  assign o_div_update = cfg.div_commit;
  assign o_drive_strength = phase_str_reg[2:0];
  assign o_output_delay_code = {fmt_misc_reg[4], delay_reg};
  assign o_coarse_delay_periods = delay_reg[5:0];
  assign o_fine_delay_steps = cfg.fine_steps;
  assign o_fine_delay_ps = cfg.fine_ps;
  assign o_output_format = cfg.fmt;
  assign o_driver_standard_select = cfg.drv_std;
  assign o_output_supply_select = cfg.supply;
  assign o_prev_format_misc = prev_misc_reg[4:0];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  chk_coarse_zero: assert property (delay_reg[5:0] == 6'h00 |-> delayed_clk == clk_true_sync_reg)
    else $error("zero coarse delay is not the undelayed clock");
  chk_coarse_max: assert property (delay_reg[5:0] == 6'h3f |->
      delayed_clk == $past(clk_true_sync_reg, 63))
    else $error("coarse delay 63 is not 63 periods");
  chk_phase_swap: assert property ((phase_str_reg[7:6] == 2'h3 &&
      fmt_misc_reg[3:0] == `ODCB_FMT_CODE_CMOS_BOTH) [*3] |=>
      o_driver_out_pos == !$past(delayed_clk) && o_driver_out_neg == $past(delayed_clk))
    else $error("swapped CMOS phase not driven");
  chk_diff_polarity: assert property ((fmt_misc_reg[3:0] == `ODCB_FMT_CODE_EXT) [*3] |=>
      o_driver_out_pos == $past(delayed_clk) && o_driver_out_neg == !$past(delayed_clk))
    else $error("differential pair polarity wrong");
  chk_cmos_neg_only: assert property (fmt_misc_reg[3:0] == `ODCB_FMT_CODE_CMOS_NEG |=>
      o_output_format == odcb_fmt_cmos_neg ##1 !o_driver_out_pos)
    else $error("negative-only CMOS format drives the positive pin");
  chk_fine_two_bit: assert property ((delay_reg[7:6] == 2'h3 && !fmt_misc_reg[4]) |=>
      o_fine_delay_steps == 3'h3 && o_fine_delay_ps == 7'h5a)
    else $error("fine delay of three steps wrong");
  chk_drv_boost: assert property (drv_misc_reg[2:0] == 3'h4 |=>
      o_driver_standard_select == odcb_drv_lvds_boost)
    else $error("code 100 did not select boosted LVDS");
  chk_drv_hcsl: assert property (drv_misc_reg[2:0] == 3'h3 |=>
      o_driver_standard_select == odcb_drv_hcsl)
    else $error("code 011 did not select HCSL");
  chk_supply_decode: assert property (drv_misc_reg[4:3] == 2'h1 |=>
      o_output_supply_select == odcb_vdd_2v5)
    else $error("supply code 01 did not declare 2.5 V");
  chk_div_output: assert property (o_div_update |=> o_output_divider ==
      {$past(div_high_reg[3:0]), $past(div_mid_reg), $past(div_low_reg)})
    else $error("divider output differs from written bytes");
  chk_unmapped_read: assert property (i_reg_rd_en &&
      (i_reg_addr < `ODCB_ADDR_PREV_MISC || i_reg_addr > `ODCB_ADDR_FMT_MISC) |=>
      o_reg_rd_valid && o_reg_rdata == 8'h00)
    else $error("unmapped read did not return zero");

  cov_cmos_both: cover property (o_output_format == odcb_fmt_cmos_both && o_driver_out_neg);
  cov_coarse_max: cover property (delay_reg[5:0] == 6'h3f && delayed_clk);
  cov_fine_four: cover property (o_fine_delay_steps == `ODCB_FINE_MAX_STEPS);
endmodule // odcb_bank
`default_nettype wire

// ### sim/odcb_bank_tb.sv
// Self-checking bench for the output divider configuration bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("Error %0t got %h exp %h", $time, g, e); end end
module odcb_bank_tb;
  import odcb_pkg::*;
  // ****************************************************************
  // Stimulus and model state
  // ****************************************************************
  logic i_ref_clk = 0;
  logic i_srst = 1;
  logic wr = 0;
  logic rd = 0;
  logic clk_t = 0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic [7:0] rdat;
  logic rdv, pos, neg, upd;
  logic [19:0] div;
  logic [2:0] str, fst;
  logic [8:0] dcode;
  logic [5:0] crs;
  logic [6:0] fps;
  logic [4:0] prv;
  odcb_format_t fmt;
  odcb_drv_std_t drv;
  odcb_supply_t sup;
  logic [7:0] mem [8'h1e:8'h28];
  int err_total = 0;
  int samples_checked = 0;
  int seed = 45;
  odcb_bank odcb_bank_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_reg_wr_en(wr),
    .i_reg_rd_en(rd), .i_reg_addr(addr), .i_reg_wdata(wdat), .o_reg_rdata(rdat),
    .o_reg_rd_valid(rdv), .i_clock_true(clk_t), .o_driver_out_pos(pos),
    .o_driver_out_neg(neg), .o_output_divider(div), .o_div_update(upd),
    .o_drive_strength(str), .o_output_delay_code(dcode), .o_coarse_delay_periods(crs),
    .o_fine_delay_steps(fst), .o_fine_delay_ps(fps), .o_output_format(fmt),
    .o_driver_standard_select(drv), .o_output_supply_select(sup), .o_prev_format_misc(prv));
  always #12.5 i_ref_clk = ~i_ref_clk;
  // ****************************************************************
  // Tasks
  // ****************************************************************
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h20: msk = 8'h0f;
      8'h21, 8'h22, 8'h24: msk = 8'hff;
      8'h23: msk = 8'hc7;
      8'h1f, 8'h25, 8'h27: msk = 8'h1f;
      default: msk = 8'h00;
    endcase
  endfunction
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    wr = 1; addr = a; wdat = d;
    @(negedge i_ref_clk);
    wr = 0;
    if (msk(a) != 8'h00) mem[a] = d & msk(a);
  endtask
  task automatic chk_rd(input logic [7:0] a);
    @(negedge i_ref_clk);
    rd = 1; addr = a;
    @(negedge i_ref_clk);
    rd = 0;
    `CHK({rdv, rdat}, {1'b1, (a == 8'h26) ? mem[a] : mem[a] & msk(a)})
  endtask
  task automatic chk_dec;
    logic [7:0] f;
    logic [2:0] fc;
    f = mem[8'h27];
    fc = {f[4], mem[8'h24][7:6]};
    @(negedge i_ref_clk);
    `CHK(fmt, (f[3:0] == 4'h0) ? odcb_fmt_ext_term : (f[3:0] == 4'h2) ? odcb_fmt_pull_up :
      (f[3:0] == 4'h1) ? odcb_fmt_pull_dn : (f[3:0] == 4'h4) ? odcb_fmt_cmos_pos :
      (f[3:0] == 4'h8) ? odcb_fmt_cmos_neg : (f[3:0] == 4'hc) ? odcb_fmt_cmos_both :
      odcb_fmt_invalid)
    `CHK(drv, (mem[8'h25][2:0] > 3'h5) ? 3'h7 : mem[8'h25][2:0])
    `CHK(sup, mem[8'h25][4:3])
    `CHK({fst, fps}, (fc > 3'h4) ? {3'h4, 7'h78} : {fc, 7'(fc * 30)})
    `CHK({dcode, crs}, {f[4], mem[8'h24], mem[8'h24][5:0]})
    `CHK({str, prv}, {mem[8'h23][2:0], mem[8'h1f][4:0]})
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [7:0] a;
    logic [3:0] fl [5];
    logic ep, en;
    int n;
    fl = '{4'h0, 4'hc, 4'h4, 4'h8, 4'h3};
    for (int i = 'h1e; i <= 'h28; i++) mem[i] = 8'h00;
    repeat (6) @(negedge i_ref_clk);
    i_srst = 0;
    w(8'h26, 8'hff);
    for (int i = 'h1e; i <= 'h28; i++) chk_rd(8'(i));
    chk_dec;
    $display("reset test done");
    for (int i = 0; i < 40; i++) begin
      a = 8'h1e + 8'($unsigned($random(seed)) % 10);
      clk_t = $random(seed);
      w(a, 8'($random(seed)));
      if (a != 8'h26) chk_rd(a);
    end
    chk_dec;
    $display("random test done");
    i_srst = 1;
    repeat (6) @(negedge i_ref_clk);
    i_srst = 0;
    for (int i = 'h1e; i <= 'h28; i++) mem[i] = 8'h00;
    chk_rd(8'h26);
    chk_rd(8'h20);
    w(8'h20, 8'h03); w(8'h21, 8'h45); w(8'h22, 8'h67);
    repeat (2) @(negedge i_ref_clk);
    `CHK(div, 20'h34567)
    w(8'h20, 8'hfa); w(8'h21, 8'hbc);
    repeat (3) @(negedge i_ref_clk);
    `CHK({upd, div}, {1'b0, 20'h34567})
    mem[8'h26] = 8'h06;
    chk_rd(8'h26);
    w(8'h22, 8'hde);
    `CHK(upd, 1'b1)
    @(negedge i_ref_clk);
    `CHK({upd, div}, {1'b0, 20'habcde})
    $display("divider test done");
    for (int i = 0; i < 32; i++) begin
      w(8'h25, 8'(i)); w(8'h27, 8'(i)); w(8'h24, 8'(i * 37));
      chk_dec;
    end
    $display("decode test done");
    clk_t = 1;
    w(8'h24, 8'h00);
    for (int j = 0; j < 5; j++) for (int p = 0; p < 4; p++) begin
      w(8'h27, {4'h0, fl[j]}); w(8'h23, {2'(p), 6'h07});
      repeat (5) @(negedge i_ref_clk);
      ep = (j == 0) ? 1'b1 : (j == 1 || j == 2) ? ~p[1] : 1'b0;
      en = (j == 1 || j == 3) ? p[0] : 1'b0;
      `CHK({pos, neg}, {ep, en})
    end
    $display("phase test done");
    w(8'h27, 8'h00);
    for (int c = 0; c < 64; c += 21) begin
      clk_t = 0;
      w(8'h24, 8'(c));
      repeat (70) @(negedge i_ref_clk);
      clk_t = 1;
      n = 0;
      do begin @(negedge i_ref_clk); n++; end while (pos !== 1'b1 && n < 80);
      `CHK(n, 3 + c)
    end
    $display("coarse delay test done");
    tally_and_finish;
  end
  // The limit is nearly twenty times the expected run, so only a true hang reaches it.
  initial begin
    #500000;
    err_total++;
    tally_and_finish;
  end
endmodule // odcb_bank_tb
`default_nettype wire
